// >>> hdl/supply_monitor_control.sv
`timescale 1ns/1ns
// Behaviour
// - level zero powers down, nonzero monitors
// - codes 1..14 pick distinct thresholds
// - all-ones code selects external sense input
// - low report while active sets flag
// - reset_on_low set: flag raises reset request
// - reset_on_low clear: flag only, no reset
// - flag latched until software writes zero
// - clear during low report sets again
// - monitor_active read-only, write has no effect
// - zero to nonzero starts 50 us delay
// - no flag, reset, active during delay
// - control write while inactive ends delay
// - nonzero to nonzero applies no delay
// - brownout reset is the only reset of control fields
// - comparator_out reads present comparator level
// - bits 7-4 level, 3,2,1,0 fields
// - reduced variant: single threshold for nonzero
module supply_monitor_control #(
  parameter bit SINGLE_LEVEL  = 1'b0,
  parameter int SETTLE_CYCLES = supply_monitor_pkg::SETTLE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       comparator_out,
  output logic      [3:0] threshold_sel,
  output logic            external_sense_sel,
  output logic            comparator_enable,
  output logic            reset_request
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  settle_if tif ();

  supply_monitor_pkg::mon_state_e state_reg;
  supply_monitor_pkg::mon_state_e state_next;

  logic [3:0] level_reg;
  logic [3:0] level_next;
  logic       ron_reg;
  logic       ron_next;
  logic       flag_reg;
  logic       flag_next;
  logic       rst_reg;
  logic       rst_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] thr_reg;
  logic [3:0] thr_next;
  logic       ext_reg;
  logic       ext_next;
  logic       en_reg;
  logic       en_next;
  logic       sync1_reg;
  logic       sync2_reg;
  logic       ctl_wr;
  logic       active;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the settling counter is only SETTLE_W bits wide
  initial
  begin
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << supply_monitor_pkg::SETTLE_W))
      $error("supply_monitor_control: SETTLE_CYCLES out of range");
  end

  assign ctl_wr = wr && (addr == supply_monitor_pkg::CONTROL_OFFSET);
  assign active = (state_reg == supply_monitor_pkg::MON_ACTIVE);

  // ----------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------
  // comparator high means the monitored voltage is low
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= comparator_out;
      sync2_reg <= sync1_reg;
    end
  end

  settle_timer #(
    .CYCLES (SETTLE_CYCLES)
  ) u_timer (
    .clk  (clk),
    .rstn (rstn),
    .tif  (tif.timer)
  );

  // ----------------------------------------------------------------
  // settling state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    tif.start  = 1'b0;
    tif.abort  = 1'b0;
    case (state_reg)
      supply_monitor_pkg::MON_OFF:
        if (level_next != supply_monitor_pkg::LEVEL_OFF)
        begin
          state_next = supply_monitor_pkg::MON_SETTLE;
          tif.start  = 1'b1;
        end
      supply_monitor_pkg::MON_SETTLE:
        if (level_next == supply_monitor_pkg::LEVEL_OFF)
        begin
          state_next = supply_monitor_pkg::MON_OFF;
          tif.abort  = 1'b1;
        end
        else if (ctl_wr || tif.done)
        begin
          state_next = supply_monitor_pkg::MON_ACTIVE;
          tif.abort  = 1'b1;
        end
      supply_monitor_pkg::MON_ACTIVE:
        // a nonzero level change keeps monitoring live
        if (level_next == supply_monitor_pkg::LEVEL_OFF)
          state_next = supply_monitor_pkg::MON_OFF;
      default:
        state_next = supply_monitor_pkg::MON_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // control fields, flag and reset request
  // ----------------------------------------------------------------
  always_comb
  begin
    level_next = level_reg;
    ron_next   = ron_reg;
    flag_next  = flag_reg;
    if (ctl_wr)
    begin
      level_next = wdata[supply_monitor_pkg::LEVEL_MSB:supply_monitor_pkg::LEVEL_LSB];
      ron_next   = wdata[supply_monitor_pkg::RESET_ON_LOW];
      // only a zero clears; a written one leaves the flag alone
      if (!wdata[supply_monitor_pkg::LOW_FLAG])
        flag_next = 1'b0;
    end
    // set wins over the software clear
    if (active && sync2_reg)
      flag_next = 1'b1;
    rst_next = active && flag_next && ron_next;
  end

  // ----------------------------------------------------------------
  // comparator selection
  // ----------------------------------------------------------------
  always_comb
  begin
    en_next  = (level_next != supply_monitor_pkg::LEVEL_OFF);
    ext_next = 1'b0;
    thr_next = level_next;
    if (SINGLE_LEVEL)
    begin
      if (en_next)
        thr_next = supply_monitor_pkg::LEVEL_SINGLE;
    end
    else if (level_next == supply_monitor_pkg::LEVEL_EXTERNAL)
      ext_next = 1'b1;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = 8'h00;
    if (rd && addr == supply_monitor_pkg::CONTROL_OFFSET)
    begin
      rdata_next[supply_monitor_pkg::LEVEL_MSB:supply_monitor_pkg::LEVEL_LSB] = level_reg;
      rdata_next[supply_monitor_pkg::RESET_ON_LOW]   = ron_reg;
      rdata_next[supply_monitor_pkg::MONITOR_ACTIVE] = active;
      rdata_next[supply_monitor_pkg::COMPARATOR_OUT] = sync2_reg;
      rdata_next[supply_monitor_pkg::LOW_FLAG]       = flag_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // rstn is the brownout reset; no other reset clears these
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= supply_monitor_pkg::MON_OFF;
      level_reg <= supply_monitor_pkg::CONTROL_RESET[7:4];
      ron_reg   <= 1'b0;
      flag_reg  <= 1'b0;
      rst_reg   <= 1'b0;
      rdata_reg <= supply_monitor_pkg::CONTROL_RESET;
      thr_reg   <= 4'h0;
      ext_reg   <= 1'b0;
      en_reg    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      level_reg <= level_next;
      ron_reg   <= ron_next;
      flag_reg  <= flag_next;
      rst_reg   <= rst_next;
      rdata_reg <= rdata_next;
      thr_reg   <= thr_next;
      ext_reg   <= ext_next;
      en_reg    <= en_next;
    end
  end

  assign rdata              = rdata_reg;
  assign threshold_sel      = thr_reg;
  assign external_sense_sel = ext_reg;
  assign comparator_enable  = en_reg;
  assign reset_request      = rst_reg;

endmodule // supply_monitor_control

// >>> hdl/supply_monitor_pkg.sv
package supply_monitor_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFFSET = 8'h56;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int LEVEL_MSB      = 7;
  localparam int LEVEL_LSB      = 4;
  localparam int RESET_ON_LOW   = 3;
  localparam int MONITOR_ACTIVE = 2;
  localparam int COMPARATOR_OUT = 1;
  localparam int LOW_FLAG       = 0;

  // ----------------------------------------------------------------
  // level codes
  // ----------------------------------------------------------------
  localparam logic [3:0] LEVEL_OFF      = 4'h0;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
  localparam logic [3:0] LEVEL_SINGLE   = 4'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 50;
  localparam int SETTLE_US      = 50;
  localparam int SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;
  localparam int SETTLE_W       = 12;

  // ----------------------------------------------------------------
  // settling state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MON_OFF    = 3'b001,
    MON_SETTLE = 3'b010,
    MON_ACTIVE = 3'b100
  } mon_state_e;

endpackage

// >>> hdl/settle_if.sv
`timescale 1ns/1ns
interface settle_if;
  logic start;
  logic abort;
  logic done;

  modport ctrl  (output start, output abort, input done);
  modport timer (input start, input abort, output done);
endinterface

// >>> hdl/settle_timer.sv
`timescale 1ns/1ns
module settle_timer #(
  parameter int CYCLES = supply_monitor_pkg::SETTLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  settle_if.timer   tif
);

  localparam int W = supply_monitor_pkg::SETTLE_W;

  initial
  begin
    if (CYCLES < 1 || CYCLES >= (1 << W))
      $error("settle_timer: CYCLES out of range");
  end

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         done_reg;
  logic         done_next;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  always_comb
  begin
    count_next = count_reg;
    done_next  = 1'b0;
    if (tif.abort)
      count_next = '0;
    else if (tif.start)
      count_next = W'(CYCLES);
    else if (count_reg != '0)
    begin
      count_next = count_reg - 1'b1;
      done_next  = (count_reg == W'(1));
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      done_reg  <= done_next;
    end
  end

  assign tif.done = done_reg;

endmodule // settle_timer

// >>> tb/supply_monitor_monitor.sv
`timescale 1ns/1ns
module supply_monitor_monitor (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       comparator_out,
  input wire logic [3:0] threshold_sel,
  input wire logic       external_sense_sel,
  input wire logic       comparator_enable,
  input wire logic       reset_request
);
  localparam logic [7:0] OFS = supply_monitor_pkg::CONTROL_OFFSET;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_enable_map;
    comparator_enable == (threshold_sel != 4'h0);
  endproperty
  a_enable_map: assert property (p_enable_map) else $error("enable off level");
  property p_ext_map;
    external_sense_sel == (threshold_sel == 4'hF);
  endproperty
  a_ext_map: assert property (p_ext_map) else $error("external select wrong");
  property p_sel_update;
    wr && addr == OFS |=> threshold_sel == $past(wdata[7:4]);
  endproperty
  a_sel_update: assert property (p_sel_update) else $error("level not applied");
  property p_other_wr;
    wr && addr != OFS |=> $stable(threshold_sel);
  endproperty
  a_other_wr: assert property (p_other_wr) else $error("foreign write taken");
  property p_rd_other;
    rd && addr != OFS |=> rdata == 8'h00;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("foreign read data");
  property p_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_comp_read;
    comparator_out [*4] ##0 (rd && addr == OFS) |=> rdata[1];
  endproperty
  a_comp_read: assert property (p_comp_read) else $error("comparator bit stale");
  property p_reset_bits;
    rd && addr == OFS && reset_request && !$past(wr) |=> rdata[3] && rdata[2] && rdata[0];
  endproperty
  a_reset_bits: assert property (p_reset_bits) else $error("reset without cause");
  property p_reset_enable;
    reset_request |-> comparator_enable || $past(comparator_enable);
  endproperty
  a_reset_enable: assert property (p_reset_enable) else $error("reset while off");
  c_reset: cover property ($rose(reset_request));
  c_ext: cover property (external_sense_sel);
  c_flag: cover property (rd ##1 rdata[0]);
endmodule // supply_monitor_monitor

bind supply_monitor_control supply_monitor_monitor u_mon (.clk(clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .comparator_out(comparator_out),
  .threshold_sel(threshold_sel), .external_sense_sel(external_sense_sel),
  .comparator_enable(comparator_enable), .reset_request(reset_request));

// >>> tb/supply_comparator_model.sv
`timescale 1ns/1ns
module supply_comparator_model (
  input  wire logic       comparator_enable,
  input  wire logic [3:0] threshold_sel,
  input  wire logic       external_sense_sel,
  input  wire logic [3:0] supply_level,
  input  wire logic       sense_low,
  output logic            comparator_out
);
  // a powered-down comparator never reports a low supply
  assign comparator_out = comparator_enable &&
    (external_sense_sel ? sense_low : (supply_level < threshold_sel));
endmodule // supply_comparator_model

// >>> tb/supply_monitor_control_tb.sv
`timescale 1ns/1ns
module supply_monitor_control_tb;
  localparam logic [7:0] OFS = supply_monitor_pkg::CONTROL_OFFSET;
  logic        clk;
  logic        rstn;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        comparator_out;
  logic [3:0]  threshold_sel;
  logic        external_sense_sel;
  logic        comparator_enable;
  logic        reset_request;
  logic [3:0]  supply_level;
  logic        sense_low;
  logic [7:0]  seen;
  logic [31:0] lfsr;
  int          err_count;
  int          checked;
  int          n;
  supply_monitor_control #(.SINGLE_LEVEL(1'b0), .SETTLE_CYCLES(20)) dut (.clk(clk),
    .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .comparator_out(comparator_out), .threshold_sel(threshold_sel),
    .external_sense_sel(external_sense_sel), .comparator_enable(comparator_enable),
    .reset_request(reset_request));
  supply_comparator_model model (.comparator_enable(comparator_enable),
    .threshold_sel(threshold_sel), .external_sense_sel(external_sense_sel),
    .supply_level(supply_level), .sense_low(sense_low), .comparator_out(comparator_out));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ctrl_val(input logic [3:0] lv, input logic p, a, c, f);
    return {lv, p, a, c, f};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic read(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 seen = rdata;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    supply_level = 4'hF;
    sense_low = 1'b0;
    lfsr = 32'h2d06;
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    read(OFS);
    check(seen, 8'h00);
    read(8'h55);
    check(seen, 8'h00);
    supply_level <= 4'h0;
    write(OFS, 8'h87);
    repeat (4) @(posedge clk);
    read(OFS);
    check(seen, ctrl_val(4'h8, 1'b0, 1'b0, 1'b1, 1'b0));
    n = 0;
    read(OFS);
    while (seen[2] !== 1'b1 && n < 40)
    begin
      read(OFS);
      n++;
    end
    if (n == 40)
    begin
      check(8'h00, 8'h01);
      finish_test();
    end
    check(8'(n >= 5), 8'h01);
    read(OFS);
    check(seen, ctrl_val(4'h8, 1'b0, 1'b1, 1'b1, 1'b1));
    check({7'h00, reset_request}, 8'h00);
    supply_level <= 4'hF;
    repeat (4) @(posedge clk);
    read(OFS);
    check(seen, ctrl_val(4'h8, 1'b0, 1'b1, 1'b0, 1'b1));
    write(OFS, 8'h80);
    read(OFS);
    check(seen, 8'h84);
    supply_level <= 4'h0;
    repeat (4) @(posedge clk);
    write(OFS, 8'h80);
    read(OFS);
    check(seen, 8'h87);
    write(OFS, 8'h98);
    repeat (2) @(posedge clk);
    check({7'h00, reset_request}, 8'h01);
    read(OFS);
    check(seen, ctrl_val(4'h9, 1'b1, 1'b1, 1'b1, 1'b1));
    // pass through zero before a new level; the 8'h50 write starts the settling delay and the 8'h58 write ends it
    write(OFS, 8'h00);
    repeat (2) @(posedge clk);
    check({6'h00, reset_request, comparator_enable}, 8'h00);
    read(OFS);
    // the clearing write met a live low report, so the flag stays latched
    check(seen, ctrl_val(4'h0, 1'b0, 1'b0, 1'b0, 1'b1));
    write(OFS, 8'h50);
    write(OFS, 8'h58);
    read(OFS);
    check(seen, ctrl_val(4'h5, 1'b1, 1'b1, 1'b1, 1'b1));
    for (int c = 1; c < 16; c++)
    begin
      lfsr = lfsr_next(lfsr);
      write(OFS, {4'(c), lfsr[3], 3'b000});
      check({threshold_sel, 3'b000, external_sense_sel}, {4'(c), 3'b000, 1'(c == 15)});
      write((lfsr[15:8] == OFS) ? 8'h00 : lfsr[15:8], lfsr[23:16]);
      check({4'h0, threshold_sel}, {4'h0, 4'(c)});
      supply_level <= lfsr[27:24];
      sense_low <= lfsr[28];
    end
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    read(OFS);
    check(seen, 8'h00);
    check({7'h00, comparator_enable}, 8'h00);
    finish_test();
  end
endmodule // supply_monitor_control_tb
